// file: scu_rx.sv
// smart-card receive channel: registers, pin filters, receiver, error out
`timescale 1ns/10ps
`default_nettype none
// Operation
// - receive only with transmit and receive enabled
// - after start bit, shift LSB first, then parity, then stop
// - after stop bits copy shift register to buffer
// - buffer load sets the receive-complete flag
// - buffer load sets the receive interrupt bit
// - reading buffer low byte clears complete flag
// - parity error drives serial output pin low
// - serial output pin selectable as open drain
// - input pins used only with direction bits zero
// - bit clock matches the card character clock
// - small division: undivided clock, generator, sixteen
// - large division: timer, halve, generator, sixteen
module scu_rx
  import scu_pkg::*;
#(
  parameter int DATA_BITS = 8
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_ce,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  output logic                   o_irq,
  input  wire logic              i_serial_input_pin,
  input  wire logic              i_external_bit_clock_pin,
  output logic                   o_serial_output_pin_out,
  output logic                   o_serial_output_pin_oe
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  scu_ctrl_s             ctrl_q;
  logic [7:0]            baud_q;
  logic [15:0]           timer_q;
  logic [DATA_BITS-1:0]  rxbuf_q;
  logic                  buf_perr_q;
  logic                  rx_done_q;
  logic [INT_W-1:0]      int_stat_q;
  logic [INT_W-1:0]      int_mask_q;
  logic [INT_W-1:0]      int_set;
  logic [2:0]            rx_sync_q;
  logic [2:0]            ck_sync_q;
  logic                  rx_lvl_q;
  logic                  ck_lvl_q;
  logic                  ext_edge;
  logic                  tick;
  scu_rx_state_e         state_q;
  logic [3:0]            tick_cnt_q;
  logic [$clog2(DATA_BITS)-1:0] bit_idx_q;
  logic                  stop_idx_q;
  logic [DATA_BITS-1:0]  shreg_q;
  logic                  perr_q;
  logic                  err_drive_q;
  logic                  ready;
  logic                  at_mid;
  logic                  at_last;
  logic                  load;
  logic                  par_bad;
  logic                  rd_lo;

  // register access decode helper
  function automatic logic hit(input logic strobe,
                               input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] reg_off);
    hit = strobe && (a == reg_off);
  endfunction : hit

  // ----------------------------------------------------------------------
  // pin filters
  // ----------------------------------------------------------------------
  // three stages; level moves only once stages two and three agree
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_sync_q <= 3'h7;
      ck_sync_q <= 3'h7;
      rx_lvl_q  <= 1'b1;
      ck_lvl_q  <= 1'b1;
    end else if (i_ce) begin
      rx_sync_q <= {rx_sync_q[1:0], i_serial_input_pin};
      ck_sync_q <= {ck_sync_q[1:0], i_external_bit_clock_pin};
      if (rx_sync_q[1] == rx_sync_q[2]) begin
        rx_lvl_q <= rx_sync_q[2];
      end
      if (ck_sync_q[1] == ck_sync_q[2]) begin
        ck_lvl_q <= ck_sync_q[2];
      end
    end
  end

  // pin clock counts only while its direction bit makes it an input
  assign ext_edge = !ctrl_q.clk_dir && (ck_sync_q[1] == ck_sync_q[2])
                    && ck_sync_q[2] && !ck_lvl_q;

  // ----------------------------------------------------------------------
  // bit clock
  // ----------------------------------------------------------------------
  scu_baud_gen u_baud_gen (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_ce       (i_ce),
    .i_clk_src  (ctrl_q.clk_src),
    .i_baud     (baud_q),
    .i_timer    (timer_q),
    .i_ext_edge (ext_edge),
    .o_tick     (tick)
  );

  // ----------------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------------
  // both enables needed, and the data pin must be an input
  assign ready   = ctrl_q.tx_en && ctrl_q.rx_en && !ctrl_q.rx_dir;
  assign at_mid  = tick && (tick_cnt_q == TICK_MID);
  assign at_last = tick && (tick_cnt_q == TICK_LAST);
  // even parity wants zero over data and parity, odd wants one
  assign par_bad = ((^shreg_q) ^ rx_lvl_q) != ctrl_q.odd_par;
  assign load    = i_ce && (state_q == ST_STOP) && at_last
                   && (stop_idx_q == ctrl_q.two_stop);

  // frame sequencing; dropping an enable abandons the frame at once
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q    <= ST_IDLE;
      tick_cnt_q <= 4'h0;
      bit_idx_q  <= '0;
      stop_idx_q <= 1'b0;
    end else if (i_ce) begin
      if (tick) begin
        tick_cnt_q <= tick_cnt_q + 4'h1;
      end
      if (!ready) begin
        state_q <= ST_IDLE;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            tick_cnt_q <= 4'h0;
            if (!rx_lvl_q) begin
              state_q <= ST_START;
            end
          end
          ST_START: begin
            // a glitch shorter than half a bit is no start bit
            if (at_mid && rx_lvl_q) begin
              state_q <= ST_IDLE;
            end else if (at_last) begin
              state_q   <= ST_DATA;
              bit_idx_q <= '0;
            end
          end
          ST_DATA: begin
            if (at_last) begin
              if (bit_idx_q == $clog2(DATA_BITS)'(DATA_BITS - 1)) begin
                state_q <= ST_PARITY;
              end else begin
                bit_idx_q <= bit_idx_q + 1'b1;
              end
            end
          end
          ST_PARITY: begin
            if (at_last) begin
              state_q    <= ST_STOP;
              stop_idx_q <= 1'b0;
            end
          end
          ST_STOP: begin
            if (at_last) begin
              if (stop_idx_q == ctrl_q.two_stop) begin
                state_q <= ST_IDLE;
              end else begin
                stop_idx_q <= 1'b1;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // data shift and parity verdict, taken at mid-bit
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shreg_q <= '0;
      perr_q  <= 1'b0;
    end else if (i_ce) begin
      if (state_q == ST_DATA && at_mid) begin
        shreg_q <= {rx_lvl_q, shreg_q[DATA_BITS-1:1]};
      end
      if (state_q == ST_START) begin
        perr_q <= 1'b0;
      end else if (state_q == ST_PARITY && at_mid) begin
        perr_q <= par_bad;
      end
    end
  end

  // error signal spans the first stop bit; stop level is not checked
  // because our own low drive would always make it look broken
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      err_drive_q <= 1'b0;
    end else if (i_ce) begin
      if (!ready) begin
        err_drive_q <= 1'b0;
      end else if (state_q == ST_PARITY && at_last) begin
        err_drive_q <= perr_q && ctrl_q.perr_out_en;
      end else if (state_q == ST_STOP && at_last) begin
        err_drive_q <= 1'b0;
      end
    end
  end

  // serial output pin: open drain only pulls low, push-pull drives
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_serial_output_pin_out <= 1'b1;
      o_serial_output_pin_oe  <= 1'b0;
    end else if (i_ce) begin
      o_serial_output_pin_out <= !err_drive_q;
      if (ctrl_q.open_drain) begin
        o_serial_output_pin_oe <= err_drive_q;
      end else begin
        o_serial_output_pin_oe <= ctrl_q.tx_en;
      end
    end
  end

  // ----------------------------------------------------------------------
  // receive buffer, completion flag and interrupts
  // ----------------------------------------------------------------------
  assign rd_lo   = hit(i_rd, i_addr, REG_RXBUF_LO);
  assign int_set = {load && rx_done_q, load && perr_q, load};

  // a load in the same cycle as the low byte read wins
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rxbuf_q    <= '0;
      buf_perr_q <= 1'b0;
      rx_done_q  <= 1'b0;
    end else if (i_ce) begin
      if (load) begin
        rxbuf_q    <= shreg_q;
        buf_perr_q <= perr_q;
        rx_done_q  <= 1'b1;
      end else if (rd_lo) begin
        rx_done_q  <= 1'b0;
      end
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      int_stat_q <= '0;
      o_irq      <= 1'b0;
    end else if (i_ce) begin
      int_stat_q <= (int_stat_q
                     & ~({INT_W{hit(i_wr, i_addr, REG_INT_STAT)}}
                         & i_wdata[INT_W-1:0])) | int_set;
      o_irq      <= |(int_stat_q & int_mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q     <= scu_ctrl_s'(CTRL_RST);
      baud_q     <= BAUD_RST;
      timer_q    <= TIMER_RST;
      int_mask_q <= MASK_RST;
    end else if (i_ce && i_wr) begin
      unique case (i_addr)
        REG_CTRL:     ctrl_q     <= scu_ctrl_s'({6'h00, i_wdata[9:0]});
        REG_BAUD:     baud_q     <= i_wdata[7:0];
        REG_TIMER:    timer_q    <= i_wdata;
        REG_INT_MASK: int_mask_q <= i_wdata[INT_W-1:0];
        default:      ;
      endcase
    end
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= '0;
      if (i_rd) begin
        unique case (i_addr)
          REG_CTRL:     o_rdata <= DATA_W'(ctrl_q);
          REG_BAUD:     o_rdata <= DATA_W'(baud_q);
          REG_TIMER:    o_rdata <= timer_q;
          REG_RXBUF_LO: o_rdata <= DATA_W'(rxbuf_q);
          REG_RXBUF_HI: o_rdata <= DATA_W'(buf_perr_q);
          REG_STATUS:   o_rdata <= DATA_W'({ready, state_q != ST_IDLE,
                                            rx_done_q});
          REG_INT_STAT: o_rdata <= DATA_W'(int_stat_q);
          REG_INT_MASK: o_rdata <= DATA_W'(int_mask_q);
          default:      o_rdata <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_not_ready_idle: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_ce && !ready) |=> state_q == ST_IDLE)
    else $error("receiver left idle while not enabled");

  a_dir_blocks_rx: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_ce && ctrl_q.rx_dir) |=> (state_q == ST_IDLE) && !err_drive_q)
    else $error("receiver active with data pin set as output");

  a_lsb_first_shift: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_ce && state_q == ST_DATA && at_mid)
    |=> shreg_q[DATA_BITS-1] == $past(rx_lvl_q))
    else $error("sampled bit not shifted in at the top");

  a_buffer_copy: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    load |=> rxbuf_q == $past(shreg_q))
    else $error("buffer does not hold the shifted character");

  a_done_on_load: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    load |=> rx_done_q && state_q == ST_IDLE)
    else $error("complete flag not set at buffer load");

  a_irq_on_load: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (load && int_mask_q[INT_RX_BIT]) |=> int_stat_q[INT_RX_BIT]
    ##1 (o_irq || !$past(i_ce) || !$past(int_mask_q[INT_RX_BIT])))
    else $error("receive interrupt not raised at buffer load");

  a_read_clears_done: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_ce && rd_lo && !load) |=> !rx_done_q)
    else $error("low byte read left complete flag set");

  a_perr_drives_low: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_ce && state_q == ST_PARITY && at_last && perr_q
     && ctrl_q.perr_out_en && ready)
    |=> err_drive_q ##1 (!o_serial_output_pin_out || !$past(i_ce)))
    else $error("parity error did not pull the output low");

  a_open_drain_off: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_ce && ctrl_q.open_drain && !err_drive_q) |=> !o_serial_output_pin_oe)
    else $error("open drain output driven while high");

  a_parity_verdict: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_ce && state_q == ST_PARITY && at_mid && ready)
    |=> perr_q == $past(par_bad))
    else $error("parity verdict not taken at mid parity bit");

endmodule : scu_rx
`default_nettype wire

// file: scu_pkg.sv
// constants, register map and types of the smart-card receive channel
`default_nettype none
package scu_pkg;

  // ----------------------------------------------------------------------
  // register bus geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_BAUD     = 4'h1;
  localparam logic [3:0] REG_TIMER    = 4'h2;
  localparam logic [3:0] REG_RXBUF_LO = 4'h3;
  localparam logic [3:0] REG_RXBUF_HI = 4'h4;
  localparam logic [3:0] REG_STATUS   = 4'h5;
  localparam logic [3:0] REG_INT_STAT = 4'h6;
  localparam logic [3:0] REG_INT_MASK = 4'h7;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int INT_W        = 3;
  localparam int INT_RX_BIT   = 0;
  localparam int INT_PERR_BIT = 1;
  localparam int INT_OVR_BIT  = 2;
  localparam int STAT_DONE_BIT  = 0;
  localparam int STAT_BUSY_BIT  = 1;
  localparam int STAT_READY_BIT = 2;
  localparam int HI_PERR_BIT    = 0;
  localparam logic [15:0]      CTRL_RST  = 16'h0000;
  localparam logic [7:0]       BAUD_RST  = 8'h00;
  localparam logic [15:0]      TIMER_RST = 16'h0000;
  localparam logic [INT_W-1:0] MASK_RST  = 3'h0;

  // ----------------------------------------------------------------------
  // bit timing: sixteen generator ticks per bit, sampled in the middle
  // ----------------------------------------------------------------------
  localparam logic [3:0] TICK_MID  = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hf;

  // bit clock source codes
  localparam logic [1:0] CLK_SRC_F1    = 2'h0;
  localparam logic [1:0] CLK_SRC_TIMER = 2'h1;
  localparam logic [1:0] CLK_SRC_EXT   = 2'h2;

  // control register layout, bit 0 is the transmit enable
  typedef struct packed {
    logic [5:0] rsvd;
    logic       two_stop;
    logic       clk_dir;
    logic       rx_dir;
    logic       odd_par;
    logic       perr_out_en;
    logic [1:0] clk_src;
    logic       open_drain;
    logic       rx_en;
    logic       tx_en;
  } scu_ctrl_s;

  // receiver states
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_START  = 5'b00010,
    ST_DATA   = 5'b00100,
    ST_PARITY = 5'b01000,
    ST_STOP   = 5'b10000
  } scu_rx_state_e;

endpackage : scu_pkg
`default_nettype wire

// file: scu_baud_gen.sv
// bit clock generator: source select, timer divider, rate generator
`timescale 1ns/10ps
`default_nettype none
module scu_baud_gen
  import scu_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_ce,
  input  wire logic [1:0]  i_clk_src,
  input  wire logic [7:0]  i_baud,
  input  wire logic [15:0] i_timer,
  input  wire logic        i_ext_edge,
  output logic             o_tick
);

  // ----------------------------------------------------------------------
  // timer divider with toggle flip-flop
  // ----------------------------------------------------------------------
  logic [15:0] tmr_cnt_q;
  logic        tgl_q;
  logic        tmr_step;
  logic        src_step;
  logic [7:0]  gen_cnt_q;

  // timer counts reload+1 clocks, then toggles: step every 2*(T+1)
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tmr_cnt_q <= 16'h0000;
      tgl_q     <= 1'b0;
    end else if (i_ce) begin
      if (tmr_cnt_q == 16'h0000) begin
        tmr_cnt_q <= i_timer;
        tgl_q     <= ~tgl_q;
      end else begin
        tmr_cnt_q <= tmr_cnt_q - 16'h0001;
      end
    end
  end

  assign tmr_step = (tmr_cnt_q == 16'h0000) && !tgl_q;

  // source choice: undivided clock, halved timer output or pin edge
  always_comb begin
    unique case (i_clk_src)
      CLK_SRC_F1:    src_step = 1'b1;
      CLK_SRC_TIMER: src_step = tmr_step;
      CLK_SRC_EXT:   src_step = i_ext_edge;
      default:       src_step = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // rate generator: divide the source by value+1
  // ----------------------------------------------------------------------
  // the x16 tick lets the receiver match the card's character clock
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gen_cnt_q <= 8'h00;
      o_tick    <= 1'b0;
    end else if (i_ce) begin
      o_tick <= 1'b0;
      if (src_step) begin
        if (gen_cnt_q == 8'h00 || gen_cnt_q > i_baud) begin // drop stale
          gen_cnt_q <= i_baud;
          o_tick    <= 1'b1;
        end else begin
          gen_cnt_q <= gen_cnt_q - 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_f1_tick_rate: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_ce && i_clk_src == CLK_SRC_F1 && i_baud == 8'h00 && $stable(i_baud)
     && $past(i_ce) && $past(i_clk_src) == CLK_SRC_F1)
    |=> o_tick)
    else $error("tick missing with undivided source and zero divider");

endmodule : scu_baud_gen
`default_nettype wire

// file: scu_card_model.sv
// smart card model: sends characters on the shared open-drain line
`timescale 1ns/10ps
`default_nettype none
module scu_card_model (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_pull
);
  // ---------------------------------------------------------------------
  // character sender
  // ---------------------------------------------------------------------
  initial o_pull = 1'b0;
  // pulls low for a zero and releases for a one; the pull-up gives high
  task automatic send(input logic [7:0] d, input bit bad, input int cyc,
                      input bit odd, input bit two, output bit err);
    logic [10:0] fr;
    fr = {1'b1, ^d ^ odd ^ bad, d, 1'b0}; // start, lsb first, parity
    err = 1'b0;
    for (int b = 0; b < (two ? 12 : 11); b++) begin
      for (int n = 0; n < cyc; n++) begin
        @(posedge i_clk);
        o_pull <= (b < 10) ? !fr[b] : 1'b0;
        // the receiver's error pull shows in the middle of the stop bit
        if (b == 10 && n == cyc / 2) err = !i_line;
      end
    end
  endtask : send
endmodule : scu_card_model
`default_nettype wire

// file: scu_rx_tb.sv
// self-checking bench for the smart-card receive channel
`timescale 1ns/10ps
`default_nettype none
module scu_rx_tb;
  import scu_pkg::*;
  // ---------------------------------------------------------------------
  // stimulus signals and tables
  // ---------------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  addr = '0;
  logic [15:0] wdata = '0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        ext = 1'b0;
  logic        ext_run = 1'b0;
  logic [1:0]  ext_ph = '0;
  logic        rd_pend = 1'b0;
  logic [15:0] rdata;
  logic        irq;
  logic        p_out;
  logic        p_oe;
  logic        pull;
  logic [35:0] exp_q[$];
  logic [35:0] e;
  int          bad_count = 0;
  int          comparisons = 0;
  int          seed = 32'h8513;
  logic [1:0]  src_t[4] = '{CLK_SRC_F1, CLK_SRC_F1, CLK_SRC_TIMER,
                            CLK_SRC_EXT};
  logic [7:0]  baud_t[4] = '{8'h00, 8'h02, 8'h00, 8'h00};
  int          cyc_t[4] = '{16, 48, 64, 64};
  // open-drain line with pull-up, shared by card and receiver
  wire         line_w = !(pull || (p_oe && !p_out));
  always #5 clk = ~clk;
  // pin clock: one rising edge every four cycles while enabled
  always @(posedge clk) begin
    ext_ph <= ext_ph + 2'h1;
    ext <= ext_run & ext_ph[1];
  end
  scu_rx dut_u (.i_core_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_irq(irq), .i_serial_input_pin(line_w),
    .i_external_bit_clock_pin(ext), .o_serial_output_pin_out(p_out),
    .o_serial_output_pin_oe(p_oe));
  scu_card_model card_u (.i_clk(clk), .i_line(line_w), .o_pull(pull));
  // ---------------------------------------------------------------------
  // compare, bus and closing tasks
  // ---------------------------------------------------------------------
  task automatic chk_word(input string nm, input logic [15:0] ex,
                          input logic [15:0] got);
    comparisons++;
    if (got !== ex) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_word
  task automatic chk_bit(input string nm, input logic ex, input logic got);
    chk_word(nm, {15'h0, ex}, {15'h0, got});
  endtask : chk_bit
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // the expectation is noted now and compared when the data stand
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] m,
                        input logic [15:0] ex);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back({a, m, ex & m});
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_chk
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk_bit("irq", 1'b1, irq);
  endtask : wait_irq
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  // read data monitor: data stand in the cycle after the strobe only
  always @(posedge clk) begin
    if (rd_pend) begin
      e = exp_q.pop_front();
      chk_word($sformatf("rdata@%h", e[35:32]), e[15:0], rdata & e[31:16]);
    end
    rd_pend <= rd;
  end
  // watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    scu_ctrl_s  c;
    logic [7:0] d;
    bit         err;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    chk_bit("out_rst", 1'b1, p_out);
    chk_bit("oe_rst", 1'b0, p_oe);
    rd_chk(REG_CTRL, 16'hffff, CTRL_RST);
    rd_chk(REG_BAUD, 16'hffff, {8'h0, BAUD_RST});
    rd_chk(REG_TIMER, 16'hffff, TIMER_RST);
    rd_chk(REG_INT_MASK, 16'hffff, {13'h0, MASK_RST});
    rd_chk(4'h8, 16'hffff, 16'h0000);
    $display("test 0 done");
    // receiver must stay deaf without the transmit enable or with pin as output
    for (int k = 0; k < 2; k++) begin
      c = '0;
      c.rx_en = 1'b1;
      c.tx_en = k[0];
      c.rx_dir = k[0];
      wr_reg(REG_CTRL, c);
      rd_chk(REG_STATUS, 16'h0004, 16'h0000);
      chk_bit("oe_push_pull", k[0], p_oe);
      card_u.send(8'h5a, 1'b0, 16, 1'b0, 1'b0, err);
      repeat (20) @(posedge clk);
      rd_chk(REG_STATUS, 16'h0001, 16'h0000);
    end
    $display("test 1 done");
    wr_reg(REG_INT_MASK, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      c = '0;
      c.tx_en = 1'b1;
      c.rx_en = 1'b1;
      c.open_drain = 1'b1;
      c.perr_out_en = 1'b1;
      c.clk_src = src_t[k];
      c.odd_par = k[0];
      c.two_stop = (k == 1);
      ext_run <= (k == 3);
      wr_reg(REG_BAUD, {8'h0, baud_t[k]});
      wr_reg(REG_TIMER, {15'h0, k == 2});
      wr_reg(REG_CTRL, c);
      rd_chk(REG_STATUS, 16'h0004, 16'h0004);
      d = $random(seed);
      card_u.send(d, k[0], cyc_t[k], k[0], k == 1, err);
      chk_bit("perr_seen", k[0], err);
      wait_irq();
      rd_chk(REG_STATUS, 16'h0001, 16'h0001);
      rd_chk(REG_INT_STAT, 16'h0007, {14'h0, k[0], 1'b1});
      rd_chk(REG_RXBUF_HI, 16'h0001, {15'h0, k[0]});
      rd_chk(REG_RXBUF_LO, 16'h00ff, {8'h0, d});
      rd_chk(REG_STATUS, 16'h0001, 16'h0000);
      wr_reg(REG_INT_MASK, 16'h0000);
      repeat (2) @(posedge clk);
      chk_bit("irq_masked", 1'b0, irq);
      wr_reg(REG_INT_STAT, 16'h0007);
      wr_reg(REG_INT_MASK, 16'h0001);
      repeat (2) @(posedge clk);
      chk_bit("irq_clear", 1'b0, irq);
      chk_bit("oe_idle", 1'b0, p_oe);
      $display("test %0d done", k + 2);
    end
    // overrun: second character lands before the first is read; the wait
    // first lets a glitch start left by the error pull die out
    repeat (40) @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      d = $random(seed);
      card_u.send(d, 1'b0, 64, 1'b1, 1'b0, err);
      repeat (40) @(posedge clk);
    end
    rd_chk(REG_INT_STAT, 16'h0007, 16'h0005);
    rd_chk(REG_RXBUF_LO, 16'h00ff, {8'h0, d});
    $display("test 6 done");
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule : scu_rx_tb
`default_nettype wire
